// ### include/sdc_pkg.sv
// Constants, register map and field layout of the SYSREF delay calibration block.
// Assumes a byte-wide register port on the device clock and a 17-bit delay path.

package sdc_pkg;

	localparam int ADDR_W  = 12;
	localparam int DATA_W  = 8;
	localparam int DELAY_W = 17;

	// ***************************************************************
	// Register map
	// ***************************************************************
	localparam logic [ADDR_W-1:0] ADDR_ENABLE  = 12'h2B0;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG  = 12'h2B1;
	localparam logic [ADDR_W-1:0] ADDR_RESULT0 = 12'h2B2;
	localparam logic [ADDR_W-1:0] ADDR_RESULT1 = 12'h2B3;
	localparam logic [ADDR_W-1:0] ADDR_RESULT2 = 12'h2B4;

	localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h05;
	localparam int                ENABLE_BIT   = 0;
	localparam int                AVG_LSB      = 2;
	localparam int                ACCUM_LSB    = 0;
	localparam int                DONE_BIT     = 17;
	localparam int                INV_BIT      = 16;

	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam logic [15:0] PERIOD_MAX0   = 16'h0080;
	localparam logic [15:0] PERIOD_MAX1   = 16'h0680;
	localparam logic [15:0] PERIOD_MAX2   = 16'h1E80;
	localparam logic [15:0] PERIOD_MAX3   = 16'h7E80;
	localparam logic [15:0] CAL_BOUND_MUL = 16'h1C80;

	typedef enum logic [2:0] {
		SDC_IDLE,
		SDC_WAIT_EDGE,
		SDC_ACCUM,
		SDC_DONE,
		SDC_FAIL
	} sdc_state_e;

endpackage : sdc_pkg

// ### design/sdc_sync.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the destination clock is the device clock.
`timescale 1ns/1ps

module sdc_sync (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule : sdc_sync

// ### design/sdc_core.sv
// SYSREF delay calibration: enable, configuration and result registers plus the
// calibration sequencer that measures SYSREF duty over accumulation windows.
// Assumes register port and manual delay setting are on clk_i; SYSREF is asynchronous.
`timescale 1ns/1ps

module sdc_core
	import sdc_pkg::*;
(
	input  wire logic                         clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic                         reg_wr_i,
	input  wire logic                         reg_rd_i,
	input  wire logic [sdc_pkg::ADDR_W-1:0]   reg_addr_i,
	input  wire logic [sdc_pkg::DATA_W-1:0]   reg_wdata_i,
	output logic      [sdc_pkg::DATA_W-1:0]   reg_rdata_o,
	input  wire logic [sdc_pkg::DELAY_W-1:0]  manual_delay_i,
	input  wire logic                         sysref_i,
	output logic      [sdc_pkg::DELAY_W-1:0]  aperture_delay_o,
	output logic                              cal_busy_o,
	output logic                              cal_fail_o
);
	import sdc_pkg::*;

	// ***************************************************************
	// Registers
	// ***************************************************************
	logic                sysref_cal_enable_r;
	logic                enable_prev_r;
	logic [3:0]          sysref_cal_config_r;
	logic [DELAY_W-1:0]  computed_delay_value_r;
	logic                cal_complete_flag_r;
	sdc_state_e          state_r;
	sdc_state_e          state_nxt;
	logic [15:0]         period_cnt_r;
	logic [7:0]          window_cnt_r;
	logic [7:0]          average_cnt_r;
	logic [16:0]         accum_r;
	logic                sysref_prev_r;
	logic                sysref_s;

	sdc_sync sdc_sync_inst (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i (sysref_i),
		.sync_o  (sysref_s)
	);

	// ***************************************************************
	// Decode and field selection
	// ***************************************************************
	wire       wr_enable    = reg_wr_i && (reg_addr_i == ADDR_ENABLE);
	wire       wr_config    = reg_wr_i && (reg_addr_i == ADDR_CONFIG);
	wire [1:0] averaging_select           = sysref_cal_config_r[AVG_LSB +: 2];
	wire [1:0] accumulation_length_select = sysref_cal_config_r[ACCUM_LSB +: 2];
	wire       cal_start    = sysref_cal_enable_r && !enable_prev_r;
	wire       sysref_rise  = sysref_s && !sysref_prev_r;

	wire [8:0] avg_count    = 9'h004 << {averaging_select, 1'b0};
	wire [8:0] win_count    = 9'h004 << {accumulation_length_select, 1'b0};
	wire [7:0] avg_last     = 8'(avg_count - 9'h001);
	wire [7:0] win_last     = 8'(win_count - 9'h001);

	// Longest SYSREF period that one accumulation length tolerates
	wire [15:0] period_max  = (accumulation_length_select == 2'h0) ? PERIOD_MAX0 :
	                          (accumulation_length_select == 2'h1) ? PERIOD_MAX1 :
	                          (accumulation_length_select == 2'h2) ? PERIOD_MAX2 :
	                                                                 PERIOD_MAX3;
	wire        period_over = (period_cnt_r >= period_max);

	// Total samples is 4^(avg+accum+2), at most 2^16; scale the sum to a 17-bit fraction.
	// The select sum needs three bits, since 3+3 would wrap in two
	wire [2:0]  sel_sum     = 3'(averaging_select) + 3'(accumulation_length_select);
	wire [3:0]  norm_shift  = 4'hC - {sel_sum, 1'b0};
	// The last window sample lands on the same edge as the result, so it is folded in
	// here; a SYSREF that is always high then gives exactly 0x10000
	wire [16:0] accum_sum   = accum_r + {16'h0000, sysref_s};
	wire [16:0] norm_delay  = 17'(accum_sum << norm_shift);

	wire        status_done = cal_complete_flag_r && sysref_cal_enable_r;
	wire [23:0] status_word = {6'h00, status_done, computed_delay_value_r};
	wire [7:0]  rd_mux      =
		(reg_addr_i == ADDR_ENABLE)  ? {7'h00, sysref_cal_enable_r} :
		(reg_addr_i == ADDR_CONFIG)  ? {4'h0, sysref_cal_config_r} :
		(reg_addr_i == ADDR_RESULT0) ? status_word[7:0] :
		(reg_addr_i == ADDR_RESULT1) ? status_word[15:8] :
		(reg_addr_i == ADDR_RESULT2) ? status_word[23:16] :
		                               8'h00;

	// Manual path keeps the same inversion/coarse/fine layout as the computed value
	wire [DELAY_W-1:0] delay_sel = sysref_cal_enable_r ? computed_delay_value_r
	                                                   : manual_delay_i;

	// ***************************************************************
	// Register port
	// ***************************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sysref_cal_enable_r <= 1'b0;
			sysref_cal_config_r <= CONFIG_RESET[3:0];
			enable_prev_r       <= 1'b0;
			reg_rdata_o         <= 8'h00;
		end else begin
			if (wr_enable)
				sysref_cal_enable_r <= reg_wdata_i[ENABLE_BIT];
			if (wr_config)
				sysref_cal_config_r <= reg_wdata_i[3:0];
			enable_prev_r <= sysref_cal_enable_r;
			if (reg_rd_i)
				reg_rdata_o <= rd_mux;
		end
	end

	// ***************************************************************
	// Calibration sequencer
	// ***************************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SDC_IDLE: begin
				if (cal_start)
					state_nxt = SDC_WAIT_EDGE;
			end
			SDC_WAIT_EDGE: begin
				if (sysref_rise)
					state_nxt = SDC_ACCUM;
				else if (period_over)
					state_nxt = SDC_FAIL;
			end
			SDC_ACCUM: begin
				if (window_cnt_r == win_last)
					state_nxt = (average_cnt_r == avg_last) ? SDC_DONE : SDC_WAIT_EDGE;
			end
			SDC_DONE: state_nxt = SDC_DONE;
			SDC_FAIL: state_nxt = SDC_FAIL;
			default:  state_nxt = SDC_IDLE;
		endcase
		// Dropping enable abandons any sequence; a fresh rising edge restarts it
		if (!sysref_cal_enable_r)
			state_nxt = SDC_IDLE;
		else if (cal_start)
			state_nxt = SDC_WAIT_EDGE;
	end

	// Every average waits at most one period then one window, so the run
	// stays well inside the 384*19*4^(avg+accum+2) cycle bound
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r       <= SDC_IDLE;
			sysref_prev_r <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			sysref_prev_r <= sysref_s;
		end
	end

	// Period counter saturates so a dead SYSREF cannot wrap back under the limit
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			period_cnt_r <= 16'h0000;
		end else if (cal_start || sysref_rise) begin
			period_cnt_r <= 16'h0000;
		end else if (period_cnt_r != 16'hFFFF) begin
			period_cnt_r <= period_cnt_r + 16'h0001;
		end
	end

	// Position inside one accumulation window
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			window_cnt_r <= 8'h00;
		end else if (state_r == SDC_ACCUM) begin
			window_cnt_r <= window_cnt_r + 8'h01;
		end else begin
			window_cnt_r <= 8'h00;
		end
	end

	// Running sum of synchronised SYSREF high samples over all averages
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			average_cnt_r <= 8'h00;
			accum_r       <= 17'h00000;
		end else if (cal_start || state_r == SDC_IDLE) begin
			average_cnt_r <= 8'h00;
			accum_r       <= 17'h00000;
		end else if (state_r == SDC_ACCUM) begin
			accum_r <= accum_sum;
			if (window_cnt_r == win_last)
				average_cnt_r <= average_cnt_r + 8'h01;
		end
	end

	// ***************************************************************
	// Result and outputs
	// ***************************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			computed_delay_value_r <= 17'h00000;
			cal_complete_flag_r    <= 1'b0;
			aperture_delay_o       <= 17'h00000;
			cal_busy_o             <= 1'b0;
			cal_fail_o             <= 1'b0;
		end else begin
			if (!sysref_cal_enable_r || cal_start)
				cal_complete_flag_r <= 1'b0;
			else if (state_r == SDC_DONE)
				cal_complete_flag_r <= 1'b1;
			if (cal_start)
				computed_delay_value_r <= 17'h00000;
			else if (state_r == SDC_ACCUM && state_nxt == SDC_DONE)
				// Bit 16 inversion, 15:8 coarse, 7:0 fine
				computed_delay_value_r <= norm_delay;
			aperture_delay_o <= delay_sel;
			cal_busy_o       <= (state_nxt == SDC_WAIT_EDGE) || (state_nxt == SDC_ACCUM);
			cal_fail_o       <= (state_nxt == SDC_FAIL);
		end
	end

endmodule : sdc_core

// ### verif/sdc_monitor.sv
// Port checker for sdc_core: register reads, delay path, start, abort, fail and run bound.
// Assumes the single clk_i domain and a bind to every sdc_core instance.
`timescale 1ns/1ps
module sdc_monitor
	import sdc_pkg::*;
(
	input wire logic               clk_i,
	input wire logic               rst_n_i,
	input wire logic               reg_wr_i,
	input wire logic               reg_rd_i,
	input wire logic [ADDR_W-1:0]  reg_addr_i,
	input wire logic [DATA_W-1:0]  reg_wdata_i,
	input wire logic [DATA_W-1:0]  reg_rdata_o,
	input wire logic [DELAY_W-1:0] manual_delay_i,
	input wire logic               sysref_i,
	input wire logic [DELAY_W-1:0] aperture_delay_o,
	input wire logic               cal_busy_o,
	input wire logic               cal_fail_o
);
	logic        en_r, sys_r;
	logic [3:0]  cfg_r;
	logic [31:0] bsy_r, gap_r;
	wire         wen = reg_wr_i && reg_addr_i == ADDR_ENABLE;
	wire         rhole = reg_rd_i && (reg_addr_i < ADDR_ENABLE || reg_addr_i > ADDR_RESULT2);
	wire [15:0]  lim = cfg_r[1] ? (cfg_r[0] ? PERIOD_MAX3 : PERIOD_MAX2)
		: (cfg_r[0] ? PERIOD_MAX1 : PERIOD_MAX0);
	wire [31:0]  bnd = 32'(CAL_BOUND_MUL) << (2 * (cfg_r[3:2] + cfg_r[1:0]) + 4);
	// Mirrors of the host-visible state; gap counts from raw SYSREF rising edges or any enable write
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_r  <= 1'b0;
			sys_r <= 1'b0;
			cfg_r <= CONFIG_RESET[3:0];
			bsy_r <= '0;
			gap_r <= '0;
		end else begin
			if (wen)
				en_r <= reg_wdata_i[0];
			if (reg_wr_i && reg_addr_i == ADDR_CONFIG)
				cfg_r <= reg_wdata_i[3:0];
			sys_r <= sysref_i;
			bsy_r <= cal_busy_o ? bsy_r + 1 : '0;
			gap_r <= ((sysref_i && !sys_r) || wen) ? '0 : gap_r + 1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// A host write that raises the enable bit, then the sequencer answering it
	sequence seq_enable_rise;
		wen && reg_wdata_i[0] && !en_r;
	endsequence
	sequence seq_busy_soon;
		##[1:3] cal_busy_o;
	endsequence
	chk_manual_delay_path: assert property (!$past(en_r) && !$past(en_r, 2)
		&& !$past(en_r, 3) && $past(rst_n_i) |-> aperture_delay_o == $past(manual_delay_i))
		else $error("delay not manual");
	chk_config_readback: assert property (reg_rd_i && reg_addr_i == ADDR_CONFIG
		|=> reg_rdata_o == {4'h0, $past(cfg_r)}) else $error("config readback");
	chk_enable_readback: assert property (reg_rd_i && reg_addr_i == ADDR_ENABLE
		|=> reg_rdata_o == {7'h0, $past(en_r)}) else $error("enable readback");
	chk_hole_reads_zero: assert property (rhole |=> reg_rdata_o == 8'h00)
		else $error("unmapped read");
	chk_done_gated: assert property (reg_rd_i && reg_addr_i == ADDR_RESULT2
		|=> reg_rdata_o[7:2] == 6'h00 && (!reg_rdata_o[1] || $past(en_r))) else $error("done");
	chk_start_busy: assert property (seq_enable_rise |-> seq_busy_soon)
		else $error("no start");
	chk_no_restart: assert property (wen && reg_wdata_i[0] && en_r && $past(en_r) && !cal_busy_o
		|=> !cal_busy_o [*3]) else $error("restart without rise");
	chk_abort_clears: assert property (wen && !reg_wdata_i[0]
		|-> ##[1:3] !cal_busy_o && !cal_fail_o) else $error("abort");
	chk_fail_late: assert property ($rose(cal_fail_o) |-> gap_r + 4 >= lim)
		else $error("early fail");
	chk_run_bound: assert property (bsy_r <= bnd) else $error("run too long");
endmodule : sdc_monitor

bind sdc_core sdc_monitor sdc_monitor_inst (.*);

// ### verif/test_sysref_delay_calibration.sv
// Self-checking bench for sdc_core: resets, config, runs per code, abort, fail.
// Assumes sdc_monitor is bound; sysref_i period per (0 holds it low).
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("FAIL %0t got %h exp %h", $time, a, b); end end
module test_sysref_delay_calibration;
	import sdc_pkg::*;
	logic               clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, sysref_i = 0;
	logic [ADDR_W-1:0]  reg_addr_i = '0;
	logic [DATA_W-1:0]  reg_wdata_i = '0, reg_rdata_o, rd;
	logic [DELAY_W-1:0] manual_delay_i = '0, aperture_delay_o;
	logic               cal_busy_o, cal_fail_o;
	logic [23:0]        res;
	logic [3:0]         cf [7] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1, 4'h2, 4'h3};
	int                 error_cnt = 0, samples_checked = 0, seed = 32'h9BDB, per = 0, sc = 0, n;
	sdc_core sdc_core_inst (.*);
	initial forever #5 clk_i = ~clk_i;
	always @(negedge clk_i) begin
		sc <= sc + 1;
		sysref_i <= per != 0 && sc % per < per / 2;
	end
	function automatic int unsigned bnd(input logic [3:0] c);
		return 7296 << (2 * (c[3:2] + c[1:0]) + 4);
	endfunction : bnd
	// Half-high SYSREF of period p: every window sees the same count of high samples
	function automatic logic [DELAY_W-1:0] expd(input logic [3:0] c, input int p);
		int hi;
		int nw;
		int na;
		hi = 0;
		nw = 4 << (2 * c[1:0]);
		na = 4 << (2 * c[3:2]);
		for (int k = 1; k <= nw; k++)
			hi += ((k % p) < p / 2) ? 1 : 0;
		return 17'((na * hi) << (12 - 2 * (c[3:2] + c[1:0])));
	endfunction : expd
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clk_i);
		{reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
		@(negedge clk_i);
		reg_wr_i = 0;
	endtask : wr
	task automatic rdr(input logic [ADDR_W-1:0] a);
		@(negedge clk_i);
		{reg_rd_i, reg_addr_i} = {1'b1, a};
		@(negedge clk_i);
		reg_rd_i = 0;
		rd = reg_rdata_o;
	endtask : rdr
	task automatic run(input logic [3:0] c);
		int k = 0;
		wr(ADDR_CONFIG, {4'h0, c});
		wr(ADDR_ENABLE, 8'h01);
		do begin
			rdr(ADDR_RESULT2);
			k += 2;
		end while (rd[1] !== 1'b1 && k < bnd(c));
		`CHK(rd[1], 1'b1)
		`CHK(cal_fail_o, 1'b0)
		rdr(ADDR_RESULT0);
		res[7:0] = rd;
		rdr(ADDR_RESULT1);
		res[15:8] = rd;
		rdr(ADDR_RESULT2);
		res[23:16] = rd;
		`CHK(res[23:17], 7'h01)
		`CHK(res[16:0], expd(c, per))
		manual_delay_i = ~manual_delay_i;
		repeat (4) @(negedge clk_i);
		`CHK(aperture_delay_o, res[16:0])
		wr(ADDR_ENABLE, 8'h00);
		repeat (4) @(negedge clk_i);
		`CHK(aperture_delay_o, manual_delay_i)
		rdr(ADDR_RESULT2);
		`CHK(rd[1], 1'b0)
	endtask : run
	task automatic close_out;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	initial begin
		#1_000_000;
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (4) @(negedge clk_i);
		rst_n_i = 1;
		rdr(ADDR_CONFIG);
		`CHK(rd, CONFIG_RESET)
		rdr(ADDR_ENABLE);
		`CHK(rd, 8'h00)
		rdr(12'h2B5);
		`CHK(rd, 8'h00)
		repeat (6) begin
			manual_delay_i = 17'($random(seed));
			n = $random(seed);
			wr(ADDR_CONFIG, 8'(n));
			`CHK(aperture_delay_o, manual_delay_i)
			rdr(ADDR_CONFIG);
			`CHK(rd, 8'(n) & 8'h0F)
		end
		per = 40;
		foreach (cf[i]) run(cf[i]);
		wr(ADDR_CONFIG, 8'h0F);
		wr(ADDR_ENABLE, 8'h01);
		repeat (50) @(negedge clk_i);
		`CHK(cal_busy_o, 1'b1)
		wr(ADDR_ENABLE, 8'h00);
		repeat (4) @(negedge clk_i);
		`CHK(cal_busy_o, 1'b0)
		`CHK(aperture_delay_o, manual_delay_i)
		wr(ADDR_CONFIG, 8'h0A);
		wr(ADDR_ENABLE, 8'h01);
		repeat (30) @(negedge clk_i);
		`CHK(cal_busy_o, 1'b1)
		rst_n_i = 0;
		@(negedge clk_i);
		`CHK(cal_busy_o, 1'b0)
		`CHK(aperture_delay_o, 17'h00000)
		rst_n_i = 1;
		rdr(ADDR_CONFIG);
		`CHK(rd, CONFIG_RESET)
		`CHK(aperture_delay_o, manual_delay_i)
		rdr(ADDR_ENABLE);
		`CHK(rd, 8'h00)
		per = 0;
		wr(ADDR_CONFIG, 8'h00);
		wr(ADDR_ENABLE, 8'h01);
		repeat (140) @(negedge clk_i);
		`CHK(cal_fail_o, 1'b1)
		wr(ADDR_ENABLE, 8'h01);
		repeat (5) @(negedge clk_i);
		`CHK(cal_busy_o, 1'b0)
		wr(ADDR_ENABLE, 8'h00);
		repeat (4) @(negedge clk_i);
		`CHK(cal_fail_o, 1'b0)
		per = 40;
		run(4'h5);
		close_out();
	end
endmodule : test_sysref_delay_calibration
